// ===== logic/serial_eeprom_command_port.sv
// serial eeprom command port with its write data fifo
`timescale 1ns/10ps

module data_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_ce,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count_q != (PW+1)'(DEPTH));
    assign o_out_valid = (count_q != '0);
    assign o_out_data  = store_q[rd_ptr_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            store_q[wr_ptr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + (PW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (PW+1)'(1);
            end
        end
    end
endmodule

// Function
// (RULE1) modification locked while supply low and for 150 ms after it comes good
// (RULE2) supply dropping below threshold locks modification at once
// (RULE3) a parameter fixes 8-bit or 16-bit word organisation
// (RULE4) instruction, address and data bits taken on shift clock rising edges
// (RULE5) serial out driven only for read data or busy status
// (RULE6) after a modify starts, selected output reads low while busy, high when ready
// (RULE7) start bit 1, two opcode bits, then 7-bit or 6-bit field
// (RULE8) opcode 10 read, 11 erase one, 01 write one with data following
// (RULE9) read drives one dummy zero then the word most significant bit first
// (RULE10) read output bits change on shift clock rising edges
// (RULE11) write starts its self-timed cycle on select falling
// (RULE12) single erase leaves every bit of the location at one
// (RULE13) power up disabled; enable command needed before modify, held until disable
// (RULE14) disable command blocks modify commands; reads unaffected
// (RULE15) clear-all sets every bit to one on select falling, no clocks needed
// (RULE16) fill-all writes its word everywhere on select falling, no clocks needed
// (RULE17) fill-all needs no prior clear-all
// (RULE18) byte page write advances address per byte, wrapping within sixteen bytes
// (RULE19) word page write advances address per word, wrapping within eight words
// (RULE20) page data buffered; programming waits for select falling
// (RULE21) continuous read increments address and wraps to zero after the top
// (RULE22) select low clears the instruction; a new read needs a full instruction
// (RULE23) modify commands while disabled or locked out are dropped, no busy
module serial_eeprom_command_port
    import eeprom_port_pkg::*;
#(
    parameter bit                  WORD16      = 1'b0,
    parameter logic [LOCK_CNT_W-1:0] LOCKOUT_CYC = LOCK_CNT_W'(eeprom_port_pkg::LOCKOUT_CYCLES),
    parameter logic [PROG_CNT_W-1:0] PROG_CYC    = PROG_CNT_W'(eeprom_port_pkg::PROG_CYCLES)
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_ce,
    input  wire logic i_select,
    input  wire logic i_shift_clock,
    input  wire logic i_serial_in,
    input  wire logic i_supply_ok,
    output logic      o_serial_out,
    output logic      o_serial_out_oe,
    output logic      o_write_lockout,
    output logic      o_busy
);
    import eeprom_port_pkg::*;

    localparam int AW = WORD16 ? FIELD_W_WORD : FIELD_W_BYTE; // RULE3
    localparam int DW = WORD16 ? DATA_W_WORD : DATA_W_BYTE;

    logic [1:0]          rst_pipe_q;
    logic                rst_b_sync;
    logic [3:0]          s1_q;
    logic [3:0]          s2_q;
    logic [3:0]          s3_q;
    logic [3:0]          filt_q;
    logic                sel_prev_q;
    logic                shift_prev_q;
    logic                sel;
    logic                shift_clock;
    logic                din;
    logic                supply;
    logic                shift_rise;
    logic                sel_fall;
    logic                shift_go;
    logic [LOCK_CNT_W-1:0] lock_cnt_q;
    logic                lockout;
    logic                modify_ok;
    shift_state_t        sh_state_q;
    exec_state_t         ex_state_q;
    mod_op_t             pend_q;
    mod_op_t             op_q;
    logic [4:0]          bit_cnt_q;
    logic [1:0]          opc_q;
    logic [6:0]          field_q;
    logic [15:0]         din_sr_q;
    logic [15:0]         dout_sr_q;
    logic [6:0]          rd_addr_q;
    logic                do_q;
    logic                rd_en_q;
    logic                wen_q;
    logic                arm_q;
    logic [6:0]          field_next;
    logic [6:0]          word_addr_next;
    logic [1:0]          ext_next;
    logic [15:0]         data_next;
    logic                field_last;
    logic                data_last;
    logic                start_bit;
    logic                launch;
    logic                push_pend_q;
    logic [15:0]         push_data_q;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    logic [15:0]         fifo_out_data;
    logic [6:0]          ptr_q;
    logic [2:0]          page_base_q;
    logic [15:0]         fill_q;
    logic [7:0]          pbuf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pmask_q;
    logic [7:0]          mem_q [MEM_BYTES];
    logic [6:0]          idx_q;
    logic [PROG_CNT_W-1:0] prog_cnt_q;
    logic                apply_we;
    logic                apply_hit;
    logic [7:0]          apply_byte;
    logic                out_q;
    logic                oe_q;

    // a word read left-aligned in 16 bits, so bit 15 always leaves first
    function automatic logic [15:0] rd_word(input logic [6:0] a);
        if (WORD16) begin
            rd_word = {mem_q[{a[5:0], 1'b0}], mem_q[{a[5:0], 1'b1}]};
        end else begin
            rd_word = {mem_q[a], 8'h00};
        end
    endfunction

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_b_sync = rst_pipe_q[1];

    // pins are asynchronous; a level is taken once stages two and three agree
    always_ff @(posedge i_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            s1_q       <= 4'h0;
            s2_q       <= 4'h0;
            s3_q       <= 4'h0;
            filt_q     <= 4'h0;
            sel_prev_q   <= 1'b0;
            shift_prev_q <= 1'b0;
        end else if (i_ce) begin
            s1_q       <= {i_supply_ok, i_select, i_shift_clock, i_serial_in};
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            filt_q     <= (filt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
            sel_prev_q   <= filt_q[2];
            shift_prev_q <= filt_q[1];
        end
    end

    assign supply   = filt_q[3];
    assign sel      = filt_q[2];
    assign shift_clock = filt_q[1];
    assign din         = filt_q[0];
    assign shift_rise  = sel && shift_clock && !shift_prev_q; // RULE4
    assign sel_fall    = sel_prev_q && !sel;
    // a word still waiting for fifo room holds off further bit capture
    assign shift_go    = shift_rise && !(push_pend_q && !fifo_in_ready);

    always_ff @(posedge i_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            lock_cnt_q <= '0;
        end else if (i_ce) begin
            if (!supply) begin
                lock_cnt_q <= '0; // RULE2
            end else if (lock_cnt_q != LOCKOUT_CYC) begin
                lock_cnt_q <= lock_cnt_q + LOCK_CNT_W'(1); // RULE1
            end
        end
    end
    assign lockout   = !supply || (lock_cnt_q != LOCKOUT_CYC); // RULE1
    assign modify_ok = wen_q && !lockout; // RULE23

    assign field_next     = {field_q[5:0], din};
    assign word_addr_next = WORD16 ? {1'b0, field_next[5:0]} : field_next; // RULE7
    assign ext_next       = WORD16 ? field_next[5:4] : field_next[6:5];
    assign data_next      = {din_sr_q[14:0], din};
    assign field_last     = shift_go && (sh_state_q == SH_FIELD) && (bit_cnt_q == 5'(AW - 1));
    assign data_last      = shift_go && (sh_state_q == SH_DATA) && (bit_cnt_q == 5'(DW - 1));
    assign start_bit      = shift_go && (sh_state_q == SH_IDLE) && din && (ex_state_q == EX_IDLE);

    always_ff @(posedge i_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            sh_state_q <= SH_IDLE;
            bit_cnt_q  <= 5'h00;
            opc_q      <= 2'h0;
            field_q    <= 7'h00;
            din_sr_q   <= 16'h0000;
            dout_sr_q  <= 16'h0000;
            rd_addr_q  <= 7'h00;
            do_q       <= 1'b0;
            rd_en_q    <= 1'b0;
            wen_q      <= 1'b0; // RULE13
            pend_q     <= MOD_NONE;
        end else if (i_ce) begin
            if (!sel) begin
                sh_state_q <= SH_IDLE; // RULE22
                rd_en_q    <= 1'b0;
                bit_cnt_q  <= 5'h00;
                if (sel_fall) begin
                    pend_q <= MOD_NONE;
                end
            end else if (shift_go) begin
                unique case (sh_state_q)
                    SH_IDLE: begin
                        if (start_bit) begin
                            sh_state_q <= SH_OPCODE; // RULE7
                            bit_cnt_q  <= 5'h00;
                            pend_q     <= MOD_NONE;
                        end
                    end
                    SH_OPCODE: begin
                        opc_q <= {opc_q[0], din};
                        if (bit_cnt_q == 5'h01) begin
                            sh_state_q <= SH_FIELD;
                            bit_cnt_q  <= 5'h00;
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 5'h01;
                        end
                    end
                    SH_FIELD: begin
                        field_q <= field_next;
                        if (field_last) begin
                            bit_cnt_q  <= 5'h00;
                            sh_state_q <= SH_IGNORE;
                            unique case (opc_q) // RULE8
                                OPC_READ: begin
                                    sh_state_q <= SH_READ; // RULE14
                                    rd_en_q    <= 1'b1;
                                    do_q       <= 1'b0; // RULE9
                                    rd_addr_q  <= word_addr_next;
                                    dout_sr_q  <= rd_word(word_addr_next);
                                end
                                OPC_WRITE: begin
                                    sh_state_q <= SH_DATA;
                                end
                                OPC_ERASE: begin
                                    if (modify_ok) begin
                                        pend_q <= MOD_ERASE_ONE; // RULE23
                                    end
                                end
                                OPC_EXT: begin
                                    unique case (ext_next)
                                        EXT_ENABLE: wen_q <= 1'b1; // RULE13
                                        EXT_DISABLE: wen_q <= 1'b0; // RULE14
                                        EXT_CLEAR: begin
                                            if (modify_ok) begin
                                                pend_q <= MOD_CLEAR_ALL; // RULE15
                                            end
                                        end
                                        EXT_FILL: sh_state_q <= SH_DATA; // RULE16
                                    endcase
                                end
                            endcase
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 5'h01;
                        end
                    end
                    SH_DATA: begin
                        din_sr_q <= data_next;
                        if (data_last) begin
                            bit_cnt_q <= 5'h00;
                            if (modify_ok) begin
                                pend_q <= (opc_q == OPC_WRITE) ? MOD_PAGE : MOD_FILL_ALL;
                            end
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 5'h01;
                        end
                    end
                    SH_READ: begin
                        do_q <= dout_sr_q[15]; // RULE10
                        if (bit_cnt_q == 5'(DW - 1)) begin
                            bit_cnt_q <= 5'h00;
                            if (WORD16) begin
                                rd_addr_q <= {1'b0, rd_addr_q[5:0] + 6'h01}; // RULE21
                                dout_sr_q <= rd_word({1'b0, rd_addr_q[5:0] + 6'h01});
                            end else begin
                                rd_addr_q <= rd_addr_q + 7'h01; // RULE21
                                dout_sr_q <= rd_word(rd_addr_q + 7'h01);
                            end
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 5'h01;
                            dout_sr_q <= {dout_sr_q[14:0], 1'b0};
                        end
                    end
                    SH_IGNORE: begin
                        bit_cnt_q <= bit_cnt_q;
                    end
                endcase
            end
        end
    end

    // words complete once per DW shift clocks, so the fifo only fills if
    // programming stalls its drain side
    always_ff @(posedge i_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            push_pend_q <= 1'b0;
            push_data_q <= 16'h0000;
        end else if (i_ce) begin
            if (data_last) begin
                push_pend_q <= 1'b1; // RULE20
                push_data_q <= WORD16 ? data_next : {8'h00, data_next[7:0]};
            end else if (fifo_in_ready) begin
                push_pend_q <= 1'b0;
            end
        end
    end

    data_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_wdata_fifo (
        .i_clk       (i_clk),
        .i_rst_b     (rst_b_sync),
        .i_ce        (i_ce),
        .i_in_valid  (push_pend_q),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (push_data_q),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_out_ready),
        .o_out_data  (fifo_out_data)
    );

    assign fifo_out_ready = (ex_state_q == EX_IDLE) || (ex_state_q == EX_DRAIN);

    always_ff @(posedge i_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            ptr_q       <= 7'h00;
            page_base_q <= 3'h0;
            fill_q      <= 16'h0000;
            pmask_q     <= '0;
        end else if (i_ce) begin
            if (start_bit) begin
                pmask_q <= '0;
            end else if (field_last) begin
                ptr_q       <= word_addr_next;
                page_base_q <= WORD16 ? word_addr_next[5:3] : word_addr_next[6:4];
            end else if (fifo_out_valid && fifo_out_ready) begin
                fill_q <= fifo_out_data;
                if (WORD16) begin
                    pbuf_q[{ptr_q[2:0], 1'b0}]  <= fifo_out_data[15:8];
                    pbuf_q[{ptr_q[2:0], 1'b1}]  <= fifo_out_data[7:0];
                    pmask_q[{ptr_q[2:0], 1'b0}] <= 1'b1;
                    pmask_q[{ptr_q[2:0], 1'b1}] <= 1'b1;
                    ptr_q <= {ptr_q[6:3], ptr_q[2:0] + 3'h1}; // RULE19
                end else begin
                    pbuf_q[ptr_q[3:0]]  <= fifo_out_data[7:0];
                    pmask_q[ptr_q[3:0]] <= 1'b1;
                    ptr_q <= {ptr_q[6:4], ptr_q[3:0] + 4'h1}; // RULE18
                end
            end
        end
    end

    assign launch = sel_fall && (pend_q != MOD_NONE) && modify_ok && (ex_state_q == EX_IDLE);

    always_ff @(posedge i_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            ex_state_q <= EX_IDLE;
            op_q       <= MOD_NONE;
            idx_q      <= 7'h00;
            prog_cnt_q <= '0;
            arm_q      <= 1'b0;
        end else if (i_ce) begin
            if (launch) begin
                arm_q <= 1'b1; // RULE6
            end else if (start_bit) begin
                arm_q <= 1'b0;
            end
            unique case (ex_state_q)
                EX_IDLE: begin
                    if (launch) begin
                        ex_state_q <= EX_DRAIN; // RULE11
                        op_q       <= pend_q;
                    end
                end
                EX_DRAIN: begin
                    if (!fifo_out_valid) begin
                        ex_state_q <= EX_APPLY;
                        idx_q      <= 7'h00;
                    end
                end
                EX_APPLY: begin
                    idx_q <= idx_q + 7'h01;
                    if (lockout) begin
                        ex_state_q <= EX_IDLE; // RULE2
                    end else if (idx_q == 7'(MEM_BYTES - 1)) begin
                        ex_state_q <= EX_WAIT;
                        prog_cnt_q <= '0;
                    end
                end
                EX_WAIT: begin
                    prog_cnt_q <= prog_cnt_q + PROG_CNT_W'(1);
                    if (prog_cnt_q == PROG_CYC - PROG_CNT_W'(1)) begin
                        ex_state_q <= EX_IDLE;
                    end
                end
            endcase
        end
    end

    // one array byte is visited per cycle, whatever the operation
    always_comb begin
        apply_hit  = 1'b0;
        apply_byte = ERASED_BYTE;
        unique case (op_q)
            MOD_NONE: apply_hit = 1'b0;
            MOD_ERASE_ONE: begin
                apply_hit = WORD16 ? (idx_q[6:1] == ptr_q[5:0]) : (idx_q == ptr_q); // RULE12
            end
            MOD_CLEAR_ALL: apply_hit = 1'b1; // RULE15
            MOD_FILL_ALL: begin
                apply_hit  = 1'b1; // RULE17
                apply_byte = (WORD16 && !idx_q[0]) ? fill_q[15:8] : fill_q[7:0]; // RULE16
            end
            MOD_PAGE: begin
                apply_hit  = (idx_q[6:4] == page_base_q) && pmask_q[idx_q[3:0]]; // RULE20
                apply_byte = pbuf_q[idx_q[3:0]];
            end
        endcase
    end

    assign apply_we = (ex_state_q == EX_APPLY) && apply_hit && !lockout; // RULE23

    always_ff @(posedge i_clk) begin
        if (i_ce && apply_we) begin
            mem_q[idx_q] <= apply_byte;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            out_q <= 1'b0;
            oe_q  <= 1'b0;
        end else if (i_ce) begin
            out_q <= rd_en_q ? do_q : (ex_state_q == EX_IDLE); // RULE6
            oe_q  <= sel && (rd_en_q || arm_q); // RULE5
        end
    end

    assign o_serial_out    = out_q;
    assign o_serial_out_oe = oe_q;
    assign o_write_lockout = lockout;
    assign o_busy          = (ex_state_q != EX_IDLE);

endmodule

// ===== logic/eeprom_port_pkg.sv
// constants and types shared by the serial eeprom command port
package eeprom_port_pkg;

    localparam int unsigned CLK_FREQ_HZ    = 20_000_000;

    // supply lockout hold after the supply comes good, each time it does
    localparam int unsigned LOCKOUT_TIME_MS = 150;
    localparam int unsigned LOCKOUT_CYCLES  =
        (LOCKOUT_TIME_MS * (CLK_FREQ_HZ / 1000) + 0) ;
    localparam int unsigned LOCK_CNT_W      = 22;

    // self-timed programming time, not given by the part
    localparam int unsigned PROG_TIME_MS   = 2;
    localparam int unsigned PROG_CYCLES    = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned PROG_CNT_W     = 16;

    // instruction format
    localparam logic [1:0] OPC_READ     = 2'h2;
    localparam logic [1:0] OPC_WRITE    = 2'h1;
    localparam logic [1:0] OPC_ERASE    = 2'h3;
    localparam logic [1:0] OPC_EXT      = 2'h0;
    localparam logic [1:0] EXT_ENABLE   = 2'h3;
    localparam logic [1:0] EXT_DISABLE  = 2'h0;
    localparam logic [1:0] EXT_CLEAR    = 2'h2;
    localparam logic [1:0] EXT_FILL     = 2'h1;

    // organisation dependent field widths
    localparam int unsigned FIELD_W_BYTE = 7;
    localparam int unsigned FIELD_W_WORD = 6;
    localparam int unsigned DATA_W_BYTE  = 8;
    localparam int unsigned DATA_W_WORD  = 16;

    // array and page geometry
    localparam int unsigned MEM_BYTES    = 128;
    localparam int unsigned PAGE_BYTES   = 16;
    localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

    // write data buffer
    localparam int unsigned FIFO_WIDTH   = 16;
    localparam int unsigned FIFO_DEPTH   = 4;

    typedef enum logic [2:0] {
        SH_IDLE,
        SH_OPCODE,
        SH_FIELD,
        SH_DATA,
        SH_READ,
        SH_IGNORE
    } shift_state_t;

    typedef enum logic [1:0] {
        EX_IDLE,
        EX_DRAIN,
        EX_APPLY,
        EX_WAIT
    } exec_state_t;

    typedef enum logic [2:0] {
        MOD_NONE,
        MOD_ERASE_ONE,
        MOD_PAGE,
        MOD_CLEAR_ALL,
        MOD_FILL_ALL
    } mod_op_t;

endpackage

// ===== dv/eeprom_port_assertions.sv
// pin-level checks on the serial eeprom command port
`timescale 1ns/10ps
module eeprom_port_checker (
    input wire logic i_clk, i_rst_b, i_select, i_supply_ok,
    input wire logic o_serial_out, o_serial_out_oe, o_write_lockout, o_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    low_lock_a: assert property (!i_supply_ok [*5] |-> o_write_lockout)
        else $error("no lockout");
    lock_hold_a: assert property ($rose(i_supply_ok) |-> o_write_lockout [*8])
        else $error("lockout short");
    idle_hiz_a: assert property (!i_select [*8] |-> !o_serial_out_oe)
        else $error("driven idle");
    drive_sel_a: assert property ($rose(o_serial_out_oe) |-> i_select)
        else $error("driven unselected");
    busy_low_a: assert property (o_busy && o_serial_out_oe && $past(o_busy, 3)
        |-> !o_serial_out) else $error("status high");
    busy_launch_a: assert property ($rose(o_busy) |-> !i_select && !o_write_lockout)
        else $error("bad launch");
    busy_span_a: assert property ($rose(o_busy) |-> o_busy [*8] ##[1:400] !o_busy)
        else $error("busy span");
    locked_idle_a: assert property (o_write_lockout && !o_busy |=> !o_busy)
        else $error("locked launch");
endmodule
bind serial_eeprom_command_port eeprom_port_checker eeprom_port_checker_inst (.*);

// ===== dv/host_model.sv
// host driving the three-wire serial link
`timescale 1ns/10ps
module host_model (
    output logic o_select, o_shift_clock, o_serial_in,
    input wire logic i_serial_out, i_serial_out_oe
);
    initial {o_select, o_shift_clock, o_serial_in} = 3'h0;
    // bits stand 200 ns each side of a rising edge, well past the pin filter
    task automatic frame(input logic [31:0] tx, input int n, m, output logic [31:0] rx);
        o_select = 1'b1;
        // an undriven output shows the inverse, so a missing enable cannot pass
        #400 rx = {30'h0, i_serial_out_oe, i_serial_out ^ ~i_serial_out_oe};
        for (int k = 0; k < n + m; k++) begin
            o_serial_in = k < n ? tx[n-1-k] : 1'b0;
            #200 rx = {rx[30:0], i_serial_out ^ ~i_serial_out_oe};
            o_shift_clock = 1'b1;
            #200 o_shift_clock = 1'b0;
        end
        #200 o_select = 1'b0;
        o_serial_in = ~o_serial_in;
        #400;
    endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench, byte organisation
`timescale 1ns/10ps
module testbench;
    import eeprom_port_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, supply = 1'b0, ce = 1'b1;
    logic        sel, sck, sdi, sdo, oe, lock, busy;
    logic [31:0] rx;
    logic [7:0]  a, d, e;
    int          failures = 0, checked = 0, cyc = 0, seed = 32'h1EE657BF;
    always #25 clk = ~clk;
    serial_eeprom_command_port #(.WORD16(1'b0), .LOCKOUT_CYC(22'h14), .PROG_CYC(16'h32))
    serial_eeprom_command_port_inst (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
        .i_select(sel), .i_shift_clock(sck), .i_serial_in(sdi), .i_supply_ok(supply),
        .o_serial_out(sdo), .o_serial_out_oe(oe), .o_write_lockout(lock), .o_busy(busy));
    host_model host_model_inst (.o_select(sel), .o_shift_clock(sck), .o_serial_in(sdi),
        .i_serial_out(sdo), .i_serial_out_oe(oe));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic [31:0] ins(logic [1:0] op, logic [6:0] f, int w);
        return {22'h0, 1'b1, op, f} << w;
    endfunction
    task automatic go(input logic [31:0] tx, input int n, input int m);
        host_model_inst.frame(tx, n, m, rx);
    endtask
    task automatic rd(input logic [6:0] ad, input logic [7:0] ex);
        go(ins(OPC_READ, ad, 0), 10, 9);
        chk(rx[8:0], {1'b0, ex});
    endtask
    task automatic ready;
        rx = 32'h0;
        for (int i = 0; i < 30 && rx[1:0] !== 2'h3; i++) go(32'h0, 0, 0);
        chk(rx[1:0], 2'h3);
    endtask
    always @(posedge clk) if (++cyc == 30000) begin
        failures++;
        summarize;
    end
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        supply = 1'b1;
        repeat (12) @(negedge clk);
        chk(lock, 1'b1);
        // with the enable low the hold count must not advance
        ce = 1'b0;
        repeat (30) @(negedge clk);
        chk(lock, 1'b1);
        ce = 1'b1;
        repeat (30) @(negedge clk);
        chk(lock, 1'b0);
        go(ins(OPC_EXT, {EXT_ENABLE, 5'h0}, 0), 10, 0);
        go(ins(OPC_EXT, {EXT_CLEAR, 5'h0}, 0), 10, 0);
        ready;
        a = 8'($random(seed));
        d = 8'($random(seed));
        rd(a[6:0], 8'hFF);
        go(ins(OPC_EXT, {EXT_DISABLE, 5'h0}, 0), 10, 0);
        go(ins(OPC_WRITE, a[6:0], 8) | d, 18, 0);
        chk(busy, 1'b0);
        rd(a[6:0], 8'hFF);
        go(ins(OPC_EXT, {EXT_ENABLE, 5'h0}, 0), 10, 0);
        go(ins(OPC_WRITE, a[6:0], 8) | d, 18, 0);
        chk(busy, 1'b1);
        go(32'h0, 0, 0);
        chk(rx[1:0], 2'h2);
        ready;
        rd(a[6:0], d);
        go(ins(OPC_ERASE, a[6:0], 0), 10, 0);
        ready;
        rd(a[6:0], 8'hFF);
        e = 8'($random(seed));
        go(ins(OPC_EXT, {EXT_FILL, 5'h0}, 8) | e, 18, 0);
        ready;
        go(ins(OPC_WRITE, 7'h7F, 16) | {d, ~d}, 26, 0);
        ready;
        rd(7'h70, ~d);
        go(ins(OPC_READ, 7'h7F, 0), 10, 17);
        chk(rx[16:0], {1'b0, d, e});
        supply = 1'b0;
        repeat (10) @(negedge clk);
        chk(lock, 1'b1);
        go(ins(OPC_WRITE, 7'h05, 8) | d, 18, 0);
        chk(busy, 1'b0);
        supply = 1'b1;
        repeat (40) @(negedge clk);
        rd(7'h05, e);
        summarize;
    end
endmodule
